/* rtl/rtc_map.svh */
/*
 Constants of the clock status and settings block: word indices of the
 clock data area, status word bit positions, the no-change code, reset values
 and timing counts. Assumes inclusion by every file that needs them.
*/
// Summary of operation
// - Reject out-of-range clock settings, flag error
// - Hours 0-23 (24h) or 1-12 morning (12h)
// - Afternoon hours coded 81-92, bit 7 set
// - Operating hours accepted up to 999999
// - Weekday 1 Sunday through 7 Saturday
// - Leap-year setting 0 to 3 years ago
// - Valid setting clears earlier error bit
// - Field FF leaves that value unchanged
// - Transfer only words fitting the region
// - Ignore settings beyond available region space
// - Clock counts in run and stop alike
// - Area writes follow mode, bits 4, 5
// - Clear request bits 2, 10, 14 when handled
// - Error bits 0, 8, 12 on rejection
// - Keep requests on bad config, space, hardware
// - Bit 0 clock error, bit 1 12-hour mode
// - Bit 3 enables reading out current time
// - Bit 2 requests clock setting transfer
// - Settings and stop time lost on reset
// - Block area word at base plus index
// - Flag area word at base plus twice index
// - Status word location given by configuration
// - All area values packed BCD
// - Stop with bit 4 refreshes words 0-3
// - Run refreshes current words continually
// - Bit 5 logs stop time in words 18-21
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

// ==========================================================
// Timing
`define RTC_SEC_NS 1000000000
`define RTC_CLK_NS 8
`define RTC_SEC_CYCLES (`RTC_SEC_NS / `RTC_CLK_NS)

// ==========================================================
// Word indices in the clock data area
`define W_CLK_SET 5'h04
`define W_PRM_SET 5'h08
`define W_OH_SET 5'h0F
`define W_LAST 5'h15

// ==========================================================
// Status word bits
`define B_CLK_ERR 0
`define B_MODE12 1
`define B_CLK_REQ 2
`define B_READ_EN 3
`define B_STOP_UPD 4
`define B_STOP_LOG 5
`define B_OH_ERR 8
`define B_OH_EN 9
`define B_OH_REQ 10
`define B_PRM_ERR 12
`define B_PRM_REQ 14

// ==========================================================
// Values
`define NO_CHANGE 8'hFF
`define RST_CAL {8'h00, 8'h04, 8'h01, 8'h04, 8'h92, 8'h12, 8'h00, 8'h00}

`endif

/* rtl/rtc_pkg.sv */
/*
 Types of the clock status and settings block.
 Assumes nothing of its surroundings.
*/
package rtc_pkg;

	// ==========================================================
	// Sequencer
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_RSTAT = 3'b001,
		S_SEL = 3'b011,
		S_RSET = 3'b010,
		S_EVAL = 3'b110,
		S_WSTAT = 3'b111,
		S_WDATA = 3'b101
	} state_type;

	typedef enum logic [1:0] {G_CLK = 2'h0, G_PRM = 2'h1, G_OH = 2'h2} group_type;

	// ==========================================================
	// Calendar, all fields packed BCD
	typedef struct packed {
		logic [7:0] leap;
		logic [7:0] wday;
		logic [7:0] day;
		logic [7:0] month;
		logic [7:0] year;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} cal_type;

	typedef struct packed {
		state_type st;
		group_type grp;
		logic [4:0] cnt;
		logic [15:0] stat;
		logic [3:0][15:0] buf_w;
		cal_type cal;
		cal_type prm;
		cal_type stopc;
		logic stop_pend;
		logic run_d;
		logic [7:0] oh_sec;
		logic [7:0] oh_min;
		logic [23:0] oh_hr;
		logic rd_en;
		logic wr_en;
		logic [15:0] addr;
		logic [15:0] wdata;
	} core_type;

	typedef struct packed {
		logic [26:0] cnt;
		logic tick;
	} div_type;

endpackage

/* rtl/rtc_status_control.sv */
/*
 Real-time clock with its status word and clock data area handling:
 counts time, date and operating hours, takes or rejects settings that
 software leaves in the area, and refreshes the area each second.
 Assumes a word memory that returns read data the cycle after it sees
 mem_rd_en, and that writes on mem_wr_en at once.
*/
`include "rtc_map.svh"
module rtc_status_control #(
	parameter int unsigned SEC_CYCLES = `RTC_SEC_CYCLES
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic run_mode,
	input wire logic param_ok,
	input wire logic hw_fault,
	input wire logic area_in_block,
	input wire logic [15:0] area_base,
	input wire logic [15:0] area_end,
	input wire logic [15:0] stat_addr,
	input wire logic [15:0] mem_rdata,
	output logic mem_rd_en,
	output logic mem_wr_en,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wdata
);
	rtc_pkg::core_type s_reg;
	rtc_pkg::core_type s_next;
	logic tick;

	setting_check_if chk_if();

	// ==========================================================
	// Leaves
	sec_divider #(
		.CYCLES(SEC_CYCLES)
	) u_div (
		.core_clk(core_clk),
		.nrst(nrst),
		.tick(tick)
	);

	setting_range_check u_chk (
		.chk(chk_if)
	);

	assign chk_if.words = s_reg.buf_w;
	assign chk_if.grp = s_reg.grp;
	assign chk_if.mode12 = s_reg.stat[`B_MODE12];

	// ==========================================================
	// BCD arithmetic
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			return {v[7:4] + 4'h1, 4'h0};
		end else begin
			return {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	function automatic logic [7:0] mrg(input logic [7:0] old, input logic [7:0] nw);
		return (nw == `NO_CHANGE) ? old : nw;
	endfunction

	function automatic logic [7:0] month_len(input rtc_pkg::cal_type c);
		case (c.month)
			8'h02: return (c.leap == 8'h00) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction

	// ==========================================================
	// One second of calendar
	function automatic rtc_pkg::cal_type cal_tick(input rtc_pkg::cal_type c,
			input logic m12);
		rtc_pkg::cal_type r;
		logic day_roll;
		r = c;
		day_roll = 1'b0;
		if (c.sec != 8'h59) begin
			r.sec = bcd_inc(c.sec);
		end else begin
			r.sec = 8'h00;
			if (c.min != 8'h59) begin
				r.min = bcd_inc(c.min);
			end else begin
				r.min = 8'h00;
				if (m12) begin
					if (c.hour == 8'h12) begin
						r.hour = 8'h81;
					end else if (c.hour == 8'h92) begin
						r.hour = 8'h01;
					end else begin
						r.hour = bcd_inc(c.hour);
						day_roll = (c.hour == 8'h91);
					end
				end else if (c.hour == 8'h23) begin
					r.hour = 8'h00;
					day_roll = 1'b1;
				end else begin
					r.hour = bcd_inc(c.hour);
				end
			end
		end
		if (day_roll) begin
			r.wday = (c.wday == 8'h07) ? 8'h01 : bcd_inc(c.wday);
			if (c.day == month_len(c)) begin
				r.day = 8'h01;
				if (c.month == 8'h12) begin
					r.month = 8'h01;
					r.year = (c.year == 8'h99) ? 8'h00 : bcd_inc(c.year);
					r.leap = (c.leap == 8'h03) ? 8'h00 : bcd_inc(c.leap);
				end else begin
					r.month = bcd_inc(c.month);
				end
			end else begin
				r.day = bcd_inc(c.day);
			end
		end
		return r;
	endfunction

	// ==========================================================
	// Clock data area addressing
	function automatic logic [16:0] word_addr(input logic [4:0] k);
		if (area_in_block) begin
			return {1'b0, area_base} + {12'h000, k};
		end else begin
			return {1'b0, area_base} + {11'h000, k, 1'b0};
		end
	endfunction

	function automatic logic in_space(input logic [4:0] k);
		return word_addr(k) <= {1'b0, area_end};
	endfunction

	function automatic logic [15:0] cal_word(input rtc_pkg::cal_type c,
			input logic [1:0] i);
		case (i)
			2'h0: return {c.leap, c.wday};
			2'h1: return {c.day, c.month};
			2'h2: return {c.year, c.hour};
			default: return {c.min, c.sec};
		endcase
	endfunction

	function automatic logic [15:0] out_word(input rtc_pkg::core_type s,
			input logic [4:0] k);
		case (k)
			5'h0C: return {8'h00, s.oh_sec};
			5'h0D: return {s.oh_min, s.oh_hr[7:0]};
			5'h0E: return {s.oh_hr[15:8], s.oh_hr[23:16]};
			5'h12, 5'h13, 5'h14, 5'h15: return cal_word(s.stopc, k[1:0] + 2'h2);
			default: return cal_word(s.cal, k[1:0]);
		endcase
	endfunction

	function automatic logic want_write(input rtc_pkg::core_type s, input logic [4:0] k);
		if (k <= 5'h03) begin
			return s.stat[`B_READ_EN] && (run_mode || s.stat[`B_STOP_UPD]);
		end else if (k >= 5'h0C && k <= 5'h0E) begin
			return s.stat[`B_READ_EN] && run_mode;
		end else if (k >= 5'h12) begin
			return s.stat[`B_STOP_LOG] && s.stop_pend;
		end else begin
			return 1'b0;
		end
	endfunction

	// ==========================================================
	// Setting groups
	function automatic logic [4:0] grp_base(input rtc_pkg::group_type g);
		case (g)
			rtc_pkg::G_PRM: return `W_PRM_SET;
			rtc_pkg::G_OH: return `W_OH_SET;
			default: return `W_CLK_SET;
		endcase
	endfunction

	function automatic logic [4:0] grp_len(input rtc_pkg::group_type g);
		return (g == rtc_pkg::G_OH) ? 5'h03 : 5'h04;
	endfunction

	function automatic int req_bit(input rtc_pkg::group_type g);
		case (g)
			rtc_pkg::G_PRM: return `B_PRM_REQ;
			rtc_pkg::G_OH: return `B_OH_REQ;
			default: return `B_CLK_REQ;
		endcase
	endfunction

	function automatic int err_bit(input rtc_pkg::group_type g);
		case (g)
			rtc_pkg::G_PRM: return `B_PRM_ERR;
			rtc_pkg::G_OH: return `B_OH_ERR;
			default: return `B_CLK_ERR;
		endcase
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		logic carry;
		logic stop_evt;
		logic [4:0] last;
		carry = 1'b0;
		stop_evt = s_reg.run_d && !run_mode;
		last = grp_base(s_reg.grp) + grp_len(s_reg.grp) - 5'h01;
		s_next = s_reg;
		s_next.rd_en = 1'b0;
		s_next.wr_en = 1'b0;
		s_next.run_d = run_mode;

		// Counting does not depend on run or stop
		if (tick) begin
			s_next.cal = cal_tick(s_reg.cal, s_reg.stat[`B_MODE12]);
			if (s_reg.stat[`B_OH_EN]) begin
				if (s_reg.oh_sec != 8'h59) begin
					s_next.oh_sec = bcd_inc(s_reg.oh_sec);
				end else begin
					s_next.oh_sec = 8'h00;
					if (s_reg.oh_min != 8'h59) begin
						s_next.oh_min = bcd_inc(s_reg.oh_min);
					end else begin
						s_next.oh_min = 8'h00;
						carry = 1'b1;
					end
				end
				for (int i = 0; i < 3; i++) begin
					if (carry) begin
						if (s_reg.oh_hr[i*8 +: 8] == 8'h99) begin
							s_next.oh_hr[i*8 +: 8] = 8'h00;
						end else begin
							s_next.oh_hr[i*8 +: 8] = bcd_inc(s_reg.oh_hr[i*8 +: 8]);
							carry = 1'b0;
						end
					end
				end
			end
		end

		// Time of the run to stop switch
		if (stop_evt) begin
			s_next.stopc = s_reg.cal;
			s_next.stop_pend = 1'b1;
		end

		case (s_reg.st)
			rtc_pkg::S_IDLE: begin
				s_next.cnt = 5'h00;
				if (tick && param_ok && !hw_fault) begin
					s_next.rd_en = 1'b1;
					s_next.addr = stat_addr;
					s_next.st = rtc_pkg::S_RSTAT;
				end
			end
			rtc_pkg::S_RSTAT: begin
				s_next.cnt = s_reg.cnt + 5'h01;
				if (s_reg.cnt == 5'h01) begin
					s_next.stat = mem_rdata;
					s_next.grp = rtc_pkg::G_CLK;
					s_next.st = rtc_pkg::S_SEL;
				end
			end
			rtc_pkg::S_SEL: begin
				s_next.cnt = 5'h00;
				if (s_reg.stat[req_bit(s_reg.grp)] && in_space(last)) begin
					s_next.st = rtc_pkg::S_RSET;
				end else if (s_reg.grp == rtc_pkg::G_OH) begin
					s_next.st = rtc_pkg::S_WSTAT;
				end else begin
					s_next.grp = rtc_pkg::group_type'(s_reg.grp + 2'h1);
				end
			end
			rtc_pkg::S_RSET: begin
				s_next.cnt = s_reg.cnt + 5'h01;
				if (s_reg.cnt < grp_len(s_reg.grp)) begin
					s_next.rd_en = 1'b1;
					s_next.addr = 16'(word_addr(grp_base(s_reg.grp) + s_reg.cnt));
				end
				if (s_reg.cnt >= 5'h02) begin
					s_next.buf_w[s_reg.cnt[1:0] - 2'h2] = mem_rdata;
				end
				if (s_reg.cnt == grp_len(s_reg.grp) + 5'h01) begin
					s_next.st = rtc_pkg::S_EVAL;
				end
			end
			rtc_pkg::S_EVAL: begin
				s_next.stat[req_bit(s_reg.grp)] = 1'b0;
				s_next.stat[err_bit(s_reg.grp)] = !chk_if.ok;
				if (chk_if.ok) begin
					case (s_reg.grp)
						rtc_pkg::G_CLK: begin
							s_next.cal.leap = mrg(s_reg.cal.leap, s_reg.buf_w[0][15:8]);
							s_next.cal.wday = mrg(s_reg.cal.wday, s_reg.buf_w[0][7:0]);
							s_next.cal.day = mrg(s_reg.cal.day, s_reg.buf_w[1][15:8]);
							s_next.cal.month = mrg(s_reg.cal.month, s_reg.buf_w[1][7:0]);
							s_next.cal.year = mrg(s_reg.cal.year, s_reg.buf_w[2][15:8]);
							s_next.cal.hour = mrg(s_reg.cal.hour, s_reg.buf_w[2][7:0]);
							s_next.cal.min = mrg(s_reg.cal.min, s_reg.buf_w[3][15:8]);
							s_next.cal.sec = mrg(s_reg.cal.sec, s_reg.buf_w[3][7:0]);
						end
						rtc_pkg::G_PRM: begin
							s_next.prm.wday = mrg(s_reg.prm.wday, s_reg.buf_w[0][7:0]);
							s_next.prm.day = mrg(s_reg.prm.day, s_reg.buf_w[1][15:8]);
							s_next.prm.month = mrg(s_reg.prm.month, s_reg.buf_w[1][7:0]);
							s_next.prm.hour = mrg(s_reg.prm.hour, s_reg.buf_w[2][7:0]);
							s_next.prm.min = mrg(s_reg.prm.min, s_reg.buf_w[3][15:8]);
							s_next.prm.sec = mrg(s_reg.prm.sec, s_reg.buf_w[3][7:0]);
						end
						default: begin
							s_next.oh_sec = mrg(s_reg.oh_sec, s_reg.buf_w[0][7:0]);
							s_next.oh_min = mrg(s_reg.oh_min, s_reg.buf_w[1][15:8]);
							s_next.oh_hr[7:0] = mrg(s_reg.oh_hr[7:0], s_reg.buf_w[1][7:0]);
							s_next.oh_hr[15:8] = mrg(s_reg.oh_hr[15:8], s_reg.buf_w[2][15:8]);
							s_next.oh_hr[23:16] = mrg(s_reg.oh_hr[23:16], s_reg.buf_w[2][7:0]);
						end
					endcase
				end
				if (s_reg.grp == rtc_pkg::G_OH) begin
					s_next.st = rtc_pkg::S_WSTAT;
				end else begin
					s_next.grp = rtc_pkg::group_type'(s_reg.grp + 2'h1);
					s_next.st = rtc_pkg::S_SEL;
				end
			end
			rtc_pkg::S_WSTAT: begin
				s_next.wr_en = 1'b1;
				s_next.addr = stat_addr;
				s_next.wdata = s_reg.stat;
				s_next.cnt = 5'h00;
				s_next.st = rtc_pkg::S_WDATA;
			end
			rtc_pkg::S_WDATA: begin
				if (want_write(s_reg, s_reg.cnt) && in_space(s_reg.cnt)) begin
					s_next.wr_en = 1'b1;
					s_next.addr = 16'(word_addr(s_reg.cnt));
					s_next.wdata = out_word(s_reg, s_reg.cnt);
				end
				s_next.cnt = s_reg.cnt + 5'h01;
				if (s_reg.cnt == `W_LAST) begin
					s_next.st = rtc_pkg::S_IDLE;
					if (s_reg.stat[`B_STOP_LOG] && !stop_evt) begin
						s_next.stop_pend = 1'b0;
					end
				end
			end
			default: begin
				s_next.st = rtc_pkg::S_IDLE;
			end
		endcase
	end

	// ==========================================================
	// State register
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s_reg <= '0;
			s_reg.cal <= `RST_CAL;
		end else begin
			s_reg <= s_next;
		end
	end

	assign mem_rd_en = s_reg.rd_en;
	assign mem_wr_en = s_reg.wr_en;
	assign mem_addr = s_reg.addr;
	assign mem_wdata = s_reg.wdata;
endmodule

/* rtl/sec_divider.sv */
/*
 Divides the core clock down to a one-cycle pulse per second.
 Assumes CYCLES is at least two.
*/
`include "rtc_map.svh"
module sec_divider #(
	parameter int unsigned CYCLES = `RTC_SEC_CYCLES
) (
	input wire logic core_clk,
	input wire logic nrst,
	output logic tick
);
	rtc_pkg::div_type d_reg;
	rtc_pkg::div_type d_next;

	// ==========================================================
	// Counter
	always_comb begin
		d_next = d_reg;
		d_next.tick = 1'b0;
		if (d_reg.cnt == 27'(CYCLES - 1)) begin
			d_next.cnt = 27'h0;
			d_next.tick = 1'b1;
		end else begin
			d_next.cnt = d_reg.cnt + 27'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			d_reg <= '0;
		end else begin
			d_reg <= d_next;
		end
	end

	assign tick = d_reg.tick;
endmodule

/* rtl/setting_check_if.sv */
/*
 Carries a group of setting words to the range checker and its verdict.
 Assumes the checker answers combinationally.
*/
interface setting_check_if;
	logic [3:0][15:0] words;
	rtc_pkg::group_type grp;
	logic mode12;
	logic ok;
	modport asker(output words, output grp, output mode12, input ok);
	modport judge(input words, input grp, input mode12, output ok);
endinterface

/* rtl/setting_range_check.sv */
/*
 Range check of one group of clock, prompt or hours-counter settings.
 Assumes words arrive in area order, high byte the left field.
*/
`include "rtc_map.svh"
module setting_range_check (
	setting_check_if.judge chk
);
	// ==========================================================
	// Field checks
	function automatic logic in_rng(input logic [7:0] b, input logic [7:0] lo,
			input logic [7:0] hi);
		return (b == `NO_CHANGE) ||
			(b[7:4] <= 4'h9 && b[3:0] <= 4'h9 && b >= lo && b <= hi);
	endfunction

	function automatic logic hour_ok(input logic [7:0] b, input logic m12);
		if (b == `NO_CHANGE) begin
			return 1'b1;
		end else if (m12) begin
			return in_rng({1'b0, b[6:0]}, 8'h01, 8'h12);
		end else begin
			return in_rng(b, 8'h00, 8'h23);
		end
	endfunction

	function automatic logic date_time_ok(input logic [3:0][15:0] w, input logic m12);
		return in_rng(w[0][7:0], 8'h01, 8'h07) &&
			in_rng(w[1][15:8], 8'h01, 8'h31) &&
			in_rng(w[1][7:0], 8'h01, 8'h12) &&
			hour_ok(w[2][7:0], m12) &&
			in_rng(w[3][15:8], 8'h00, 8'h59) &&
			in_rng(w[3][7:0], 8'h00, 8'h59);
	endfunction

	// ==========================================================
	// Verdict
	always_comb begin
		case (chk.grp)
			rtc_pkg::G_CLK: chk.ok = date_time_ok(chk.words, chk.mode12) &&
				in_rng(chk.words[0][15:8], 8'h00, 8'h03) &&
				in_rng(chk.words[2][15:8], 8'h00, 8'h99);
			rtc_pkg::G_PRM: chk.ok = date_time_ok(chk.words, chk.mode12);
			rtc_pkg::G_OH: chk.ok = in_rng(chk.words[0][7:0], 8'h00, 8'h59) &&
				in_rng(chk.words[1][15:8], 8'h00, 8'h59) &&
				in_rng(chk.words[1][7:0], 8'h00, 8'h99) &&
				in_rng(chk.words[2][15:8], 8'h00, 8'h99) &&
				in_rng(chk.words[2][7:0], 8'h00, 8'h99);
			default: chk.ok = 1'b0;
		endcase
	end
endmodule

/* verification/area_mem_model.sv */
/*
 Word memory holding the clock data area and the status word.
 Assumes one read answered the cycle after each read request.
*/
module area_mem_model (
	input wire logic core_clk,
	input wire logic mem_rd_en,
	input wire logic mem_wr_en,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:255];
	initial mem_rdata = 16'h0000;
	// ==========================================================
	// Stale read data toggles instead of holding
	always @(posedge core_clk) begin
		if (mem_rd_en) begin
			mem_rdata <= mem[mem_addr];
		end else begin
			mem_rdata <= ~mem_rdata;
		end
		if (mem_wr_en) begin
			mem[mem_addr] <= mem_wdata;
		end
	end
endmodule

/* verification/rtc_status_control_tb.sv */
/*
 Testbench: plays software through the memory words of the clock area.
 Assumes the design, its monitor and the memory model are compiled.
*/
module rtc_status_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SEC = 100;
	typedef struct {int k; logic [15:0] v; logic m12; logic ok;} case_type;
	logic core_clk, nrst, run_mode, param_ok, hw_fault, area_in_block, mem_rd_en, mem_wr_en;
	logic [15:0] area_base, area_end, stat_addr, mem_rdata, mem_addr, mem_wdata, st, acc1;
	int n_mismatch, num_checks;
	logic [15:0] base [4] = '{16'h0103, 16'h1506, 16'h9922, 16'h5910};
	case_type tbl [23] = '{'{6, 16'h9923, 0, 1}, '{7, 16'h5960, 0, 0}, '{7, 16'h0000, 0, 1},
		'{7, 16'h6010, 0, 0}, '{5, 16'h0006, 0, 0}, '{5, 16'h3112, 0, 1}, '{5, 16'h3206, 0, 0},
		'{5, 16'h1513, 0, 0}, '{5, 16'h1500, 0, 0}, '{6, 16'h9924, 0, 0}, '{4, 16'h0108, 0, 0},
		'{4, 16'h0307, 0, 1}, '{4, 16'h0100, 0, 0}, '{4, 16'h0403, 0, 0}, '{6, 16'h0000, 0, 1},
		'{6, 16'h9981, 0, 0}, '{6, 16'h9981, 1, 1}, '{6, 16'h9900, 1, 0}, '{6, 16'h9912, 1, 1},
		'{6, 16'h9993, 1, 0}, '{6, 16'h9913, 1, 0}, '{6, 16'h9992, 1, 1}, '{4, 16'h0101, 0, 1}};

	rtc_status_control #(.SEC_CYCLES(SEC)) i_dut (.core_clk, .nrst, .run_mode, .param_ok,
		.hw_fault, .area_in_block, .area_base, .area_end, .stat_addr, .mem_rdata, .mem_rd_en,
		.mem_wr_en, .mem_addr, .mem_wdata);
	area_mem_model i_mem (.core_clk, .mem_rd_en, .mem_wr_en, .mem_addr, .mem_wdata, .mem_rdata);

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// ==========================================================
	// Tasks
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	function automatic logic [15:0] wa(input int k);
		return area_in_block ? area_base + 16'(k) : area_base + 16'(2 * k);
	endfunction
	function automatic logic [15:0] rd(input int k);
		return i_mem.mem[wa(k)];
	endfunction
	task automatic wr(input int k, input logic [15:0] v);
		i_mem.mem[wa(k)] = v;
	endtask
	// One full second: device reads, handles and writes back
	task automatic sq(input logic [15:0] s);
		i_mem.mem[stat_addr] = s;
		repeat (SEC) @(posedge core_clk);
		#1;
		st = i_mem.mem[stat_addr];
	endtask
	task automatic grp(input string nm, input int k, input logic [15:0] v, s, m, e);
		wr(k, v);
		sq(s);
		check(nm, st & m, e);
	endtask

	initial begin
		repeat (SEC * 60) @(posedge core_clk);
		n_mismatch++;
		stop_test();
	end

	// ==========================================================
	// Main sequence
	initial begin
		logic [15:0] m;
		nrst = 1'b0;
		{run_mode, param_ok, hw_fault, area_in_block} = 4'hD;
		area_base = 16'h0040;
		area_end = 16'h00FF;
		stat_addr = 16'h0010;
		n_mismatch = 0;
		num_checks = 0;
		acc1 = 16'h1506;
		for (int i = 0; i < 256; i++) i_mem.mem[i] = 16'h0000;
		repeat (3) @(posedge core_clk);
		#1 nrst = 1'b1;
		repeat (70) @(posedge core_clk);
		#1;
		sq(16'h0008);
		check("rst_date", rd(1), 16'h0104);
		check("rst_time", rd(2), 16'h9212);
		foreach (tbl[i]) begin
			for (int j = 0; j < 4; j++) wr(4 + j, base[j]);
			wr(tbl[i].k, tbl[i].v);
			m = (tbl[i].k == 7) ? 16'hFF00 : 16'hFFFF;
			sq(16'h000C | {14'h0000, tbl[i].m12, st[0]});
			check("clk_req", 16'(st[2]), 16'h0000);
			check("clk_err", 16'(st[0]), 16'(!tbl[i].ok));
			if (tbl[i].ok) begin
				check("clk_take", rd(tbl[i].k - 4) & m, tbl[i].v & m);
				acc1 = (tbl[i].k == 5) ? tbl[i].v : 16'h1506;
			end else begin
				check("clk_keep", rd(1), acc1);
			end
		end
		{m, acc1} = {16'hFFFF, 16'h2006};
		wr(4, m);
		wr(6, m);
		wr(7, m);
		grp("ff_stat", 5, 16'h20FF, 16'h000C, 16'h0005, 16'h0000);
		check("ff_day", rd(1), 16'h2006);
		check("ff_leap", rd(0), 16'h0101);
		wr(15, 16'h0000);
		wr(17, 16'h9999);
		grp("oh_ok", 16, 16'h0099, 16'h0408, 16'h0500, 16'h0000);
		check("oh_word", rd(14), 16'h9999);
		grp("oh_bad", 16, 16'h6099, 16'h0408, 16'h0500, 16'h0100);
		grp("oh_clr", 16, 16'h0099, 16'h0708, 16'h0500, 16'h0000);
		wr(8, 16'h0001);
		wr(10, 16'h0012);
		wr(11, 16'h0000);
		grp("pr_ok", 9, 16'h0101, 16'h4008, 16'h5000, 16'h0000);
		check("oh_count", rd(12), 16'h0001);
		grp("pr_bad", 9, 16'h0113, 16'h4008, 16'h5000, 16'h1000);
		grp("pr_clr", 9, 16'h0101, 16'h5008, 16'h5000, 16'h0000);
		for (int j = 0; j < 4; j++) wr(4 + j, base[j]);
		param_ok = 1'b0;
		grp("no_param", 5, 16'h1506, 16'h000C, 16'hFFFF, 16'h000C);
		{param_ok, hw_fault} = 2'b11;
		grp("hw_bad", 5, 16'h1506, 16'h000C, 16'hFFFF, 16'h000C);
		hw_fault = 1'b0;
		area_end = 16'h0046;
		grp("too_small", 5, 16'h1506, 16'h000C, 16'h0005, 16'h0004);
		area_end = 16'h00FF;
		grp("no_read", 1, 16'hA5A5, 16'h0000, 16'hFFFF, 16'h0000);
		check("no_read", rd(1), 16'hA5A5);
		wr(13, 16'h5A5A);
		run_mode = 1'b0;
		sq(16'h0038);
		check("stop_cur", rd(1), acc1);
		check("stop_log", rd(19), acc1);
		check("stop_oh", rd(13), 16'h5A5A);
		grp("stop_off", 1, 16'hA5A5, 16'h0028, 16'hFFFF, 16'h0028);
		check("stop_off", rd(1), 16'hA5A5);
		{run_mode, area_in_block, area_base} = {2'b10, 16'h0080};
		sq(16'h0008);
		check("flag_word", i_mem.mem[16'h0082], acc1);
		stop_test();
	end
endmodule

/* verification/rtc_status_monitor.sv */
/*
 Concurrent checks on the memory side of the clock status block.
 Assumes it is bound to the top module and sees only its ports.
*/
module rtc_status_monitor #(
	parameter int unsigned SEC_CYCLES = 100
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic run_mode,
	input wire logic param_ok,
	input wire logic hw_fault,
	input wire logic area_in_block,
	input wire logic [15:0] area_base,
	input wire logic [15:0] area_end,
	input wire logic [15:0] stat_addr,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_rd_en,
	input wire logic mem_wr_en,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Status word as read at sequence start
	logic stat_rd_d;
	logic [15:0] stat_seen;
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			stat_rd_d <= 1'b0;
			stat_seen <= 16'h0000;
		end else begin
			stat_rd_d <= mem_rd_en && mem_addr == stat_addr;
			if (stat_rd_d) begin
				stat_seen <= mem_rdata;
			end
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// ==========================================================
	// Properties
	property p_start_ok;
		mem_rd_en && mem_addr == stat_addr && !$past(mem_rd_en)
			|-> $past(param_ok) && !$past(hw_fault);
	endproperty
	a_start_ok: assert property (p_start_ok) else $error("access without valid setup");
	property p_rd_range;
		mem_rd_en && mem_addr != stat_addr |-> mem_addr <= area_end;
	endproperty
	a_rd_range: assert property (p_rd_range) else $error("read beyond region");
	property p_wr_range;
		mem_wr_en && mem_addr != stat_addr |-> mem_addr <= area_end;
	endproperty
	a_wr_range: assert property (p_wr_range) else $error("write beyond region");
	property p_block_addr;
		mem_wr_en && area_in_block && mem_addr != stat_addr |-> 16'(mem_addr - area_base) < 16'd22;
	endproperty
	a_block_addr: assert property (p_block_addr) else $error("block word outside area");
	property p_flag_addr;
		mem_wr_en && !area_in_block && mem_addr != stat_addr
			|-> mem_addr[0] == area_base[0] && 16'(mem_addr - area_base) < 16'd44;
	endproperty
	a_flag_addr: assert property (p_flag_addr) else $error("flag word misplaced");
	property p_stop_words;
		mem_wr_en && area_in_block && !run_mode && !$past(run_mode) && mem_addr != stat_addr
			|-> 16'(mem_addr - area_base) < 16'd4 || 16'(mem_addr - area_base) > 16'd17;
	endproperty
	a_stop_words: assert property (p_stop_words) else $error("stop mode wrote run words");
	property p_read_gate;
		mem_wr_en && area_in_block && 16'(mem_addr - area_base) < 16'd4 |-> stat_seen[3];
	endproperty
	a_read_gate: assert property (p_read_gate) else $error("time written while gated");
	property p_stat_kept;
		mem_wr_en && mem_addr == stat_addr |-> (mem_wdata & 16'hAAFA) == (stat_seen & 16'hAAFA);
	endproperty
	a_stat_kept: assert property (p_stat_kept) else $error("software status bits altered");
	property p_err_rise;
		mem_wr_en && mem_addr == stat_addr
			|-> (!(mem_wdata[0] && !stat_seen[0]) || (stat_seen[2] && !mem_wdata[2]))
			&& (!(mem_wdata[8] && !stat_seen[8]) || (stat_seen[10] && !mem_wdata[10]))
			&& (!(mem_wdata[12] && !stat_seen[12]) || (stat_seen[14] && !mem_wdata[14]));
	endproperty
	a_err_rise: assert property (p_err_rise) else $error("error set without handled request");
	property p_err_clear;
		mem_wr_en && mem_addr == stat_addr
			|-> (!(stat_seen[0] && !mem_wdata[0]) || (stat_seen[2] && !mem_wdata[2]))
			&& (!(stat_seen[8] && !mem_wdata[8]) || (stat_seen[10] && !mem_wdata[10]))
			&& (!(stat_seen[12] && !mem_wdata[12]) || (stat_seen[14] && !mem_wdata[14]));
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("error cleared without setting");
	property p_seq_len;
		mem_rd_en && mem_addr == stat_addr |-> ##[1:60] (mem_wr_en && mem_addr == stat_addr);
	endproperty
	a_seq_len: assert property (p_seq_len) else $error("status not written back in time");
	c_err: cover property (mem_wr_en && mem_addr == stat_addr && mem_wdata[0]);
	c_log: cover property (mem_wr_en && area_in_block && 16'(mem_addr - area_base) == 16'd19);
	c_flag: cover property (mem_wr_en && !area_in_block);
endmodule
bind rtc_status_control rtc_status_monitor #(.SEC_CYCLES(SEC_CYCLES)) i_mon (.core_clk, .nrst,
	.run_mode, .param_ok, .hw_fault, .area_in_block, .area_base, .area_end, .stat_addr,
	.mem_rdata, .mem_rd_en, .mem_wr_en, .mem_addr, .mem_wdata);
